// *** design/limit_pattern_sel.sv ***
/*
  selects the output pattern from limit results.
  assumes fail results and patterns are stable while used.
*/
`timescale 1ns/1ps
`default_nettype none
module limit_pattern_sel (
  // patterns
  input  wire out_port_pkg::line_vec_t pat_lo1_i,
  input  wire out_port_pkg::line_vec_t pat_hi1_i,
  input  wire out_port_pkg::line_vec_t pat_lo2_i,
  input  wire out_port_pkg::line_vec_t pat_hi2_i,
  input  wire out_port_pkg::line_vec_t pat_pass_i,
  // carrier
  limit_sel_if.sel                     sel
);
  // ----------------------------------------------------------------
  // priority pick
  // ----------------------------------------------------------------
  wire [3:0] act = sel.fail & {sel.set_en[1], sel.set_en[1], sel.set_en[0], sel.set_en[0]};
  out_port_pkg::pick_t pick;
  always_comb begin
    if (act[0])      pick = out_port_pkg::PICK_LO1;
    else if (act[1]) pick = out_port_pkg::PICK_HI1;
    else if (act[2]) pick = out_port_pkg::PICK_LO2;
    else if (act[3]) pick = out_port_pkg::PICK_HI2;
    else             pick = out_port_pkg::PICK_PASS;
  end
  always_comb begin
    case (pick)
      out_port_pkg::PICK_LO1: sel.pattern = pat_lo1_i;
      out_port_pkg::PICK_HI1: sel.pattern = pat_hi1_i;
      out_port_pkg::PICK_LO2: sel.pattern = pat_lo2_i;
      out_port_pkg::PICK_HI2: sel.pattern = pat_hi2_i;
      default:                sel.pattern = pat_pass_i;
    endcase
  end
endmodule : limit_pattern_sel
`default_nettype wire

// *** design/limit_sel_if.sv ***
/*
  carrier between the port top and the limit pattern selector.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface limit_sel_if;
  logic [3:0]              fail;
  logic [1:0]              set_en;
  out_port_pkg::line_vec_t pattern;
  modport top (output fail, output set_en, input pattern);
  modport sel (input fail, input set_en, output pattern);
endinterface : limit_sel_if
`default_nettype wire

// *** design/out_port_params.svh ***
/*
  constants for the limit-binning digital output port.
  assumes a 50 MHz system clock and inclusion by bare name.
*/
`ifndef OUT_PORT_PARAMS_SVH
`define OUT_PORT_PARAMS_SVH

// ----------------------------------------------------------------
// registers (word byte addresses)
// ----------------------------------------------------------------
`define REG_STATE      4'h0
`define REG_POLARITY   4'h4
`define REG_TOGGLE     4'h8
`define REG_LIMCTRL    4'hC

// ----------------------------------------------------------------
// limit control register fields
// ----------------------------------------------------------------
`define LIM_EN_SET1    0
`define LIM_EN_SET2    1
`define LIM_STROBE_EN  2

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define STATE_RST      4'h0
`define POL_RST        4'h0
`define LIM_RST        3'h0
`define PAT_RST        4'h0
`define PINS_RST       4'h0
`define SYNC_RST       3'h0
`define CLK_MHZ        50
`define STROBE_MIN_NS  10000
`define STROBE_CYCLES  ((`STROBE_MIN_NS * `CLK_MHZ) / 1000 + 1)

`endif

// *** design/out_port_pkg.sv ***
/*
  types for the limit-binning digital output port.
  assumes nothing of its surroundings.
*/
`default_nettype none
package out_port_pkg;
  typedef logic [3:0] line_vec_t;
  typedef enum logic [2:0] {
    PICK_LO1,
    PICK_HI1,
    PICK_LO2,
    PICK_HI2,
    PICK_PASS
  } pick_t;
endpackage : out_port_pkg
`default_nettype wire

// *** design/output_port_config.sv ***
/*
  four-line digital output port with limit binning, wishbone slave.
  assumes a synchronous limit engine on MCLK_I and one-cycle done pulse.
*/
// Implementation choices: the Wishbone slave port and the placing of the registers.
`include "out_port_params.svh"
`timescale 1ns/1ps
`default_nettype none
module output_port_config #(
  parameter int STROBE_CYC = `STROBE_CYCLES
) (
  // clock and reset
  input  wire logic        MCLK_I,
  input  wire logic        SRST_I,
  // wishbone slave
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [3:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  // limit engine
  input  wire logic [3:0]  LIM_FAIL_I,
  input  wire logic        LIM_DONE_I,
  input  wire logic [3:0]  PAT_LO1_I,
  input  wire logic [3:0]  PAT_HI1_I,
  input  wire logic [3:0]  PAT_LO2_I,
  input  wire logic [3:0]  PAT_HI2_I,
  input  wire logic [3:0]  PAT_PASS_I,
  // port pins
  output logic [3:0]       OUT_LINE_O,
  input  wire logic        CAL_IN_I,
  output logic             CAL_LEVEL_O
);
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  // state    : on/off per line, bit n is line n+1
  // polarity : a set bit makes that line active-low
  // toggle   : a write flips the line named by data[1:0]; a read gives the pins and the calibration level in bit 4
  // limctrl  : two set enables and the strobe enable; a read adds the strobe level
  // other addresses read as zero and ignore writes

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic hits(input logic [3:0] adr, input logic [3:0] reg_adr);
    hits = (adr == reg_adr);
  endfunction : hits

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // ~ACK_O keeps a request still held in its ack cycle from being taken twice
  wire req      = CYC_I & STB_I & ~ACK_O;
  wire wr       = req & WE_I & SEL_I[0];
  wire wr_state = wr & hits(ADR_I, `REG_STATE);
  wire wr_pol   = wr & hits(ADR_I, `REG_POLARITY);
  wire wr_tog   = wr & hits(ADR_I, `REG_TOGGLE);
  wire wr_lim   = wr & hits(ADR_I, `REG_LIMCTRL);

  logic [3:0] state_q;
  logic [3:0] pol_q;
  logic [2:0] lim_q;
  logic [3:0] pins_q;
  logic       strobe_q;
  localparam int SCNT_W = $clog2(STROBE_CYC + 1);
  logic [SCNT_W-1:0] scnt_q;
  logic [2:0] cal_sync_q;

  wire any_lim   = lim_q[`LIM_EN_SET1] | lim_q[`LIM_EN_SET2];
  wire strobe_en = lim_q[`LIM_STROBE_EN];
  wire strobe_on = wr_lim & DAT_I[`LIM_STROBE_EN] & ~strobe_en;
  wire strobe_off = wr_lim & ~DAT_I[`LIM_STROBE_EN] & strobe_en;

  // ----------------------------------------------------------------
  // line four after strobe disable
  // ----------------------------------------------------------------
  // switching the strobe off must not move line four, so it keeps the
  // strobe level until software or a new reading gives it a fresh value
  logic hold4_q;
  wire  hold4_end = strobe_on | ((wr_state | wr_tog) & ~any_lim) | LIM_DONE_I;
  wire  line4_own = strobe_en | hold4_q;

  // a disable in the same cycle as a clearing event wins
  always_ff @(posedge MCLK_I) begin
    if (SRST_I)          hold4_q <= 1'b0;
    else if (strobe_off) hold4_q <= 1'b1;
    else if (hold4_end)  hold4_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // limit selection
  // ----------------------------------------------------------------
  limit_sel_if lsel ();
  assign lsel.fail   = LIM_FAIL_I;
  assign lsel.set_en = {lim_q[`LIM_EN_SET2], lim_q[`LIM_EN_SET1]};
  limit_pattern_sel u_sel (
    .pat_lo1_i  (PAT_LO1_I),
    .pat_hi1_i  (PAT_HI1_I),
    .pat_lo2_i  (PAT_LO2_I),
    .pat_hi2_i  (PAT_HI2_I),
    .pat_pass_i (PAT_PASS_I),
    .sel        (lsel)
  );

  // ----------------------------------------------------------------
  // line values
  // ----------------------------------------------------------------
  // pattern updates per reading and on enabling control, so a stale fail vector is never shown
  logic [3:0] lim_pat_q;
  // enabling control shows the pass pattern at once; the pick for the fail vector only follows the next reading
  wire       lim_pat_load = LIM_DONE_I | (wr_lim & ~any_lim);
  wire [3:0] logical = any_lim ? lim_pat_q : state_q;
  wire [3:0] with_strobe = line4_own ? {strobe_q, logical[2:0]} : logical;
  wire [3:0] pins_d = with_strobe ^ pol_q;

  // only two select bits: upper data bits of a toggle write are ignored
  wire [3:0] tog_mask = 4'h1 << DAT_I[1:0];

  always_ff @(posedge MCLK_I) begin
    if (SRST_I)        state_q <= `STATE_RST;
    else if (wr_state) state_q <= DAT_I[3:0];
    else if (wr_tog)   state_q <= state_q ^ tog_mask;
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I)      pol_q <= `POL_RST;
    else if (wr_pol) pol_q <= DAT_I[3:0];
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I)      lim_q <= `LIM_RST;
    else if (wr_lim) lim_q <= DAT_I[2:0];
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I)            lim_pat_q <= `PAT_RST;
    else if (lim_pat_load) lim_pat_q <= lsel.pattern;
  end

  // ----------------------------------------------------------------
  // binning strobe
  // ----------------------------------------------------------------
  // disable keeps strobe_q frozen, so line four holds its level
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      strobe_q <= 1'b0;
      scnt_q   <= '0;
    end else if (strobe_on) begin
      strobe_q <= 1'b0;
      scnt_q   <= '0;
    end else if (strobe_en && LIM_DONE_I) begin
      strobe_q <= 1'b1;
      scnt_q   <= SCNT_W'(STROBE_CYC);
    end else if (strobe_en && scnt_q != '0) begin
      scnt_q <= scnt_q - 1'b1;
      if (scnt_q == SCNT_W'(1)) strobe_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pin register
  // ----------------------------------------------------------------
  // pins come from a flop: glitch-free relay drive for one cycle of latency
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) pins_q <= `PINS_RST;
    else        pins_q <= pins_d;
  end
  assign OUT_LINE_O = pins_q;

  // ----------------------------------------------------------------
  // calibration input, visible only to software
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) cal_sync_q <= `SYNC_RST;
    else        cal_sync_q <= {cal_sync_q[1:0], CAL_IN_I};
  end

  // a level counts once two late stages agree, so metastability never reaches software
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) CAL_LEVEL_O <= 1'b0;
    else if (cal_sync_q[2] == cal_sync_q[1]) CAL_LEVEL_O <= cal_sync_q[2];
  end

  // ----------------------------------------------------------------
  // read and acknowledge
  // ----------------------------------------------------------------
  logic [31:0] rd_d;
  always_comb begin
    case (ADR_I)
      `REG_STATE:    rd_d = {28'h0, state_q};
      `REG_POLARITY: rd_d = {28'h0, pol_q};
      `REG_TOGGLE:   rd_d = {27'h0, CAL_LEVEL_O, pins_q};
      `REG_LIMCTRL:  rd_d = {28'h0, strobe_q, lim_q};
      default:       rd_d = 32'h0;
    endcase
  end

  // data falls back to zero outside the ack cycle, so a late sample reads nothing stale
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h0;
    end else begin
      ACK_O <= req;
      DAT_O <= (req && !WE_I) ? rd_d : 32'h0;
    end
  end
endmodule : output_port_config
`default_nettype wire

// *** verification/handler_model.sv ***
/* parts handler on the far side of the port pins.
   assumes active-high sense on line four during strobe tests. */
`timescale 1ns/1ps
`default_nettype none
module handler_model (
  // port pins
  input  wire logic [3:0] line_i,
  // bin taken at the last strobe
  output logic      [2:0] bin_o
);
  initial bin_o = 3'h0;
  // lines one to three are only trusted at the rising strobe
  always @(posedge line_i[3]) bin_o <= line_i[2:0];
endmodule : handler_model
`default_nettype wire

// *** verification/output_port_assertions.sv ***
/* checker for the output port: bus handshake, reset, pin isolation.
   assumes it is bound to output_port_config. */
`timescale 1ns/1ps
`default_nettype none
module output_port_assertions (
  // clock and reset
  input wire logic        MCLK_I,
  input wire logic        SRST_I,
  // bus
  input wire logic        CYC_I,
  input wire logic        STB_I,
  input wire logic        WE_I,
  input wire logic [3:0]  ADR_I,
  input wire logic [31:0] DAT_O,
  input wire logic        ACK_O,
  // limits and pins
  input wire logic        LIM_DONE_I,
  input wire logic [3:0]  OUT_LINE_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (SRST_I);
  sequence req_s; CYC_I && STB_I && !ACK_O; endsequence
  // no bus or limit traffic: nothing may move lines one to three
  sequence quiet_s; !(CYC_I && STB_I) && !LIM_DONE_I; endsequence
  a_ack_follows_req: assert property (req_s |=> ACK_O) else $error("ack missing");
  a_ack_one_cycle: assert property (ACK_O |=> !ACK_O) else $error("ack too long");
  a_ack_has_cause: assert property (ACK_O |-> $past(CYC_I && STB_I)) else $error("stray ack");
  a_no_ack_idle: assert property (!(CYC_I && STB_I) |=> !ACK_O) else $error("idle ack");
  a_dat_idle_zero: assert property (!ACK_O |-> DAT_O == 32'h0) else $error("data outside ack");
  a_unmapped_read_zero: assert property (req_s and !WE_I && ADR_I[1:0] != 2'h0 |=> DAT_O == 32'h0)
    else $error("unmapped read");
  a_reset_clears_pins: assert property (disable iff (1'b0) SRST_I |=> OUT_LINE_O == 4'h0)
    else $error("pins after reset");
  a_cal_isolated: assert property (quiet_s [*4] |=> $stable(OUT_LINE_O[2:0]))
    else $error("pins moved unprompted");
endmodule : output_port_assertions
bind output_port_config output_port_assertions u_chk (.MCLK_I(MCLK_I), .SRST_I(SRST_I),
  .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
  .LIM_DONE_I(LIM_DONE_I), .OUT_LINE_O(OUT_LINE_O));
`default_nettype wire

// *** verification/test_output_port_config.sv ***
/* self-checking bench for output_port_config with a handler model.
   assumes the checker is bound from its own file. */
`timescale 1ns/1ps
`default_nettype none
module test_output_port_config;
  localparam int SC = 5;
  logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, done = 1'b0;
  logic        cal = 1'b0, ack, cal_o;
  logic [3:0]  adr = 4'h0, sel = 4'hF, fail = 4'h0, pins;
  logic [31:0] wd = 32'h0, rd, dout;
  logic [2:0]  bin;
  int          mismatches = 0, n_checks = 0;
  initial forever #10 clk = ~clk;
  // short strobe keeps the run brief; expectations use SC
  output_port_config #(.STROBE_CYC(SC)) dut (.MCLK_I(clk), .SRST_I(rst), .CYC_I(cyc),
    .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wd), .DAT_O(dout), .ACK_O(ack),
    .LIM_FAIL_I(fail), .LIM_DONE_I(done), .PAT_LO1_I(4'h1), .PAT_HI1_I(4'h2),
    .PAT_LO2_I(4'h3), .PAT_HI2_I(4'h4), .PAT_PASS_I(4'h8), .OUT_LINE_O(pins),
    .CAL_IN_I(cal), .CAL_LEVEL_O(cal_o));
  handler_model hm (.line_i(pins), .bin_o(bin));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  task automatic chk_rd(input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk_rd
  task automatic chk_pin(input logic [3:0] e);
    chk_rd({28'h0, e}, {28'h0, pins});
  endtask : chk_pin
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
    do @(posedge clk); while (ack !== 1'b1);
    rd = dout;
    {cyc, stb} <= 2'b00;
    @(posedge clk);
  endtask : wb
  task automatic settle;
    repeat (2) @(posedge clk);
  endtask : settle
  task automatic pulse(input logic [3:0] f);
    {fail, done} <= {f, 1'b1};
    @(posedge clk);
    done <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pulse
  task automatic t_manual;
    logic [3:0] s;
    s = 4'h5;
    chk_pin(4'h0);
    wb(1'b1, 4'h0, 32'h5);
    wb(1'b0, 4'h0, 32'h0);
    chk_rd(32'h5, rd);
    sel <= 4'hE;
    wb(1'b1, 4'h0, 32'hF);
    sel <= 4'hF;
    wb(1'b0, 4'h0, 32'h0);
    chk_rd(32'h5, rd);
    settle;
    chk_pin(4'h5);
    wb(1'b1, 4'h4, 32'h3);
    settle;
    chk_pin(4'h6);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, 4'h8, 32'(i));
      s[i] = ~s[i];
      wb(1'b0, 4'h0, 32'h0);
      chk_rd({28'h0, s}, rd);
    end
    wb(1'b1, 4'h2, 32'hF);
    wb(1'b0, 4'h2, 32'h0);
    chk_rd(32'h0, rd);
    wb(1'b1, 4'h4, 32'h0);
  endtask : t_manual
  task automatic t_limits;
    logic [3:0] fv [7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h6, 4'hC, 4'h0};
    logic [3:0] ex [7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h2, 4'h3, 4'h8};
    cal <= 1'b1;
    wb(1'b1, 4'hC, 32'h3);
    wb(1'b1, 4'h0, 32'h0);
    settle;
    chk_pin(4'h8);
    wb(1'b0, 4'h8, 32'h0);
    chk_rd(32'h18, rd);
    chk_rd(32'h1, {31'h0, cal_o});
    for (int k = 0; k < 7; k++) begin
      pulse(fv[k]);
      chk_pin(ex[k]);
    end
  endtask : t_limits
  task automatic t_strobe;
    int n;
    n = 0;
    wb(1'b1, 4'hC, 32'h7);
    settle;
    chk_pin(4'h0);
    {fail, done} <= {4'h1, 1'b1};
    @(posedge clk);
    done <= 1'b0;
    cal  <= 1'b0;
    repeat (20) begin
      @(posedge clk);
      n += int'(pins[3] === 1'b1);
    end
    chk_rd(32'(SC), 32'(n));
    chk_rd(32'h1, {29'h0, bin});
    chk_rd(32'h0, {31'h0, cal_o});
    {fail, done} <= {4'h1, 1'b1};
    @(posedge clk);
    done <= 1'b0;
    wb(1'b1, 4'hC, 32'h3);
    settle;
    chk_pin(4'h9);
    pulse(4'h1);
    chk_pin(4'h1);
  endtask : t_strobe
  task automatic t_reset;
    wb(1'b1, 4'h4, 32'hF);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    settle;
    chk_pin(4'h0);
    wb(1'b0, 4'h4, 32'h0);
    chk_rd(32'h0, rd);
    wb(1'b0, 4'hC, 32'h0);
    chk_rd(32'h0, rd);
  endtask : t_reset
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    wrap_up;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_manual;
    t_limits;
    t_strobe;
    t_reset;
    wrap_up;
  end
endmodule : test_output_port_config
`default_nettype wire
